//--- core/cfg_ctl_pkg.sv
package cfg_ctl_pkg;
    // register indices in the configuration register space
    localparam logic [4:0] CTL_IDX = 5'h05;
    localparam logic [4:0] MASK_IDX = 5'h06;
    localparam logic [4:0] STATE_IDX = 5'h08;
    // byte addresses on the register bus: four times the index
    localparam logic [7:0] CTL_ADDR = {1'b0, CTL_IDX, 2'b00};
    localparam logic [7:0] MASK_ADDR = {1'b0, MASK_IDX, 2'b00};
    localparam logic [7:0] STATE_ADDR = {1'b0, STATE_IDX, 2'b00};
    // frame register indices seen by the access checker
    localparam logic [4:0] FRAME_ADDR_IDX = 5'h01;
    localparam logic [4:0] FRAME_DATA_IDX = 5'h02;
    // control word field positions
    localparam int KEY_SRC_BIT = 31;
    localparam int PORT_SEL_BIT = 30;
    localparam int OVERHEAT_BIT = 12;
    localparam int FALLBACK_DIS_BIT = 10;
    localparam int MEM_MASK_N_BIT = 8;
    localparam int FAR_SRC_BIT = 7;
    localparam int DECRYPT_BIT = 6;
    localparam int SEC_HI_BIT = 5;
    localparam int SEC_LO_BIT = 4;
    localparam int PERSIST_BIT = 3;
    localparam int USER_FLOAT_N_BIT = 0;
    // reset values
    localparam logic [31:0] CTL_RESET = 32'h0000_0481;
    localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [1:0] SEC_RESET = 2'h0;
    // security level encodings
    localparam logic [1:0] SEC_OPEN = 2'h0;
    localparam logic [1:0] SEC_NO_READ = 2'h1;
    // frame address readback width
    localparam int FAR_W = 24;
endpackage : cfg_ctl_pkg

//--- core/config_control_word_zero.sv
// Contract
// RULE_01 - control word sits at configuration register index 00101
// RULE_02 - every control word write passes through the write mask
// RULE_03 - bit 31 picks key source: 0 battery memory, 1 fuse key
// RULE_04 - key source is frozen once decrypt enable is set; bit stays read/write
// RULE_05 - bit 30 picks internal port: 0 top, 1 bottom
// RULE_06 - bit 12 enables power-down on over-temperature alarm
// RULE_07 - bit 10: 0 falls back on failure, 1 halts (default)
// RULE_08 - bit 8 low masks changeable memory readback, default masked
// RULE_09 - bit 7: 0 returns ECC error frame, 1 readback CRC address
// RULE_10 - bit 6 enables the bitstream decryptor, default off
// RULE_11 - bits 5:4 security: 00 open, 01 no readback, 1x no access
// RULE_12 - security level restricts the external port only
// RULE_13 - new level acts at encrypted stream end or after startup
// RULE_14 - at levels 00/01 encrypted writes reach only frame regs
// RULE_15 - bit 3 keeps the configuration interface alive after done
// RULE_16 - bit 0 low floats all user I/Os, default active
// RULE_17 - user float plus configuration float also turns off pull-ups
// RULE_18 - write mask register sits at index 00110
// RULE_19 - configuration float low holds all user I/Os floating
// RULE_20 - mask bit 1 updates control bit, 0 keeps it
// RULE_21 - reads return every bit, reserved bits keep written value
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module config_control_word_zero
    import cfg_ctl_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins from outside the clock domain
    input wire logic cfg_io_float_n,
    input wire logic overheat_alarm,
    // configuration logic status
    input wire logic startup_finished,
    input wire logic encrypted_stream_end,
    input wire logic config_done,
    input wire logic config_failed,
    input wire logic [FAR_W-1:0] ecc_error_frame_addr,
    input wire logic [FAR_W-1:0] readback_crc_addr,
    // access check requests
    input wire logic acc_valid,
    input wire logic acc_internal,
    input wire logic acc_write,
    input wire logic acc_encrypted,
    input wire logic [4:0] acc_reg,
    output logic acc_grant,
    output logic acc_deny,
    // control outputs
    output logic key_source_select,
    output logic internal_port_select,
    output logic overheat_power_down,
    output logic fallback_start,
    output logic config_halt,
    output logic readback_mem_mask_n,
    output logic [FAR_W-1:0] frame_addr_readback,
    output logic decrypt_enable,
    output logic [1:0] security_level,
    output logic cfg_port_active,
    output logic user_io_hiz,
    output logic pullup_off
);
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [31:0] mask_q;
    logic key_q;
    logic [1:0] sec_q;
    logic startup_seen_q;
    logic cfg_float_n_s;
    logic alarm_s;
    logic setup_ph;
    logic access_ph;
    logic wr_ctl;
    logic wr_mask;
    logic mapped;
    logic [31:0] state_word;

    // pins cross into pclk first; configuration float resets asserted
    sync2 #(
        .WIDTH(2),
        .RST_VAL(2'b00)
    ) u_pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in({cfg_io_float_n, overheat_alarm}),
        .sync_out({cfg_float_n_s, alarm_s})
    );

    // bus phase decode; writes land only in the completing access cycle
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable && pready;
    assign mapped = (paddr == CTL_ADDR) || (paddr == MASK_ADDR) || (paddr == STATE_ADDR);
    assign wr_ctl = access_ph && pwrite && (paddr == CTL_ADDR) && !pslverr; // RULE_01
    assign wr_mask = access_ph && pwrite && (paddr == MASK_ADDR) && !pslverr; // RULE_18

    // masked merge: a clear mask bit holds the old control bit
    always_comb begin
        ctl_d = (ctl_q & ~mask_q) | (pwdata & mask_q); // RULE_02 RULE_20
    end

    // read-only view of the block's own effective state
    assign state_word = {24'h00_0000, pullup_off, user_io_hiz, cfg_port_active,
                         config_halt, sec_q, startup_seen_q, key_q};

    // apb handshake: no wait state; read data leaves a flop loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            // writes to the state view and byte-partial writes are refused
            pslverr <= !mapped || (pwrite && (paddr == STATE_ADDR))
                       || (pwrite && (pstrb != 4'hF));
            if (pwrite || !mapped) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == CTL_ADDR) begin
                prdata <= ctl_q; // RULE_21
            end else if (paddr == MASK_ADDR) begin
                prdata <= mask_q;
            end else begin
                prdata <= state_word;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control word: reserved bits are stored like any other
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= CTL_RESET;
        end else if (wr_ctl) begin
            ctl_q <= ctl_d; // RULE_02 RULE_21
        end
    end

    // write mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= pwdata; // RULE_18
        end
    end

    // effective key source: follows writes only while decryption was off,
    // so the write that sets decrypt enable still captures its key bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q <= CTL_RESET[KEY_SRC_BIT];
        end else if (wr_ctl && !ctl_q[DECRYPT_BIT]) begin
            key_q <= ctl_d[KEY_SRC_BIT]; // RULE_04
        end
    end

    // security level goes live at encrypted stream end with decryption on, or once startup is done with it off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= SEC_RESET;
            startup_seen_q <= 1'b0;
        end else begin
            startup_seen_q <= startup_finished;
            if (ctl_q[DECRYPT_BIT] && encrypted_stream_end) begin
                sec_q <= ctl_q[SEC_HI_BIT:SEC_LO_BIT]; // RULE_13
            end else if (!ctl_q[DECRYPT_BIT] && startup_finished) begin
                sec_q <= ctl_q[SEC_HI_BIT:SEC_LO_BIT]; // RULE_13
            end
        end
    end

    // access checker: internal port bypasses the security level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_grant <= 1'b0;
            acc_deny <= 1'b0;
        end else if (!acc_valid) begin
            acc_grant <= 1'b0;
            acc_deny <= 1'b0;
        end else if (acc_internal) begin
            acc_grant <= 1'b1; // RULE_12
            acc_deny <= 1'b0;
        end else if (sec_q[1]) begin
            acc_grant <= 1'b0; // RULE_11
            acc_deny <= 1'b1;
        end else if (!acc_write) begin
            acc_grant <= (sec_q == SEC_OPEN); // RULE_11
            acc_deny <= (sec_q != SEC_OPEN);
        end else if (acc_encrypted) begin
            acc_grant <= (acc_reg == FRAME_ADDR_IDX) || (acc_reg == FRAME_DATA_IDX); // RULE_14
            acc_deny <= !((acc_reg == FRAME_ADDR_IDX) || (acc_reg == FRAME_DATA_IDX));
        end else begin
            acc_grant <= 1'b1;
            acc_deny <= 1'b0;
        end
    end

    // field outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_source_select <= CTL_RESET[KEY_SRC_BIT];
            internal_port_select <= CTL_RESET[PORT_SEL_BIT];
            readback_mem_mask_n <= CTL_RESET[MEM_MASK_N_BIT];
            decrypt_enable <= CTL_RESET[DECRYPT_BIT];
            security_level <= SEC_RESET;
            frame_addr_readback <= '0;
        end else begin
            key_source_select <= key_q; // RULE_03
            internal_port_select <= ctl_q[PORT_SEL_BIT]; // RULE_05
            readback_mem_mask_n <= ctl_q[MEM_MASK_N_BIT]; // RULE_08
            decrypt_enable <= ctl_q[DECRYPT_BIT]; // RULE_10
            security_level <= sec_q; // RULE_11
            frame_addr_readback <= ctl_q[FAR_SRC_BIT] ? readback_crc_addr
                                                      : ecc_error_frame_addr; // RULE_09
        end
    end

    // power, failure and port persistence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overheat_power_down <= 1'b0;
            fallback_start <= 1'b0;
            config_halt <= 1'b0;
            cfg_port_active <= 1'b1;
        end else begin
            overheat_power_down <= ctl_q[OVERHEAT_BIT] && alarm_s; // RULE_06
            // fallback is a pulse per failure report; halt is sticky till reset
            fallback_start <= config_failed && !ctl_q[FALLBACK_DIS_BIT]; // RULE_07
            if (config_failed && ctl_q[FALLBACK_DIS_BIT]) begin
                config_halt <= 1'b1; // RULE_07
            end
            cfg_port_active <= !config_done || ctl_q[PERSIST_BIT]; // RULE_15
        end
    end

    // user I/O float and pull-up control; both floats are active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_io_hiz <= 1'b1;
            pullup_off <= 1'b0;
        end else begin
            user_io_hiz <= !ctl_q[USER_FLOAT_N_BIT] || !cfg_float_n_s; // RULE_16 RULE_19
            pullup_off <= !ctl_q[USER_FLOAT_N_BIT] && !cfg_float_n_s; // RULE_17
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        ##1 (psel && penable && pready);
    endsequence

    property p_apb_one_wait;
        s_setup |-> s_answer;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("no answer after setup"); // RULE_01

    property p_ctl_masked;
        wr_ctl |=> ctl_q == (($past(ctl_q) & ~$past(mask_q)) | ($past(pwdata) & $past(mask_q)));
    endproperty
    a_ctl_masked: assert property (p_ctl_masked) else $error("masked write wrong"); // RULE_02

    property p_ctl_stable;
        !wr_ctl |=> $stable(ctl_q);
    endproperty
    a_ctl_stable: assert property (p_ctl_stable) else $error("control changed without write"); // RULE_20

    property p_key_frozen;
        ctl_q[DECRYPT_BIT] |=> $stable(key_q);
    endproperty
    a_key_frozen: assert property (p_key_frozen) else $error("key changed under decrypt"); // RULE_04

    property p_key_out;
        ##1 key_source_select == $past(key_q);
    endproperty
    a_key_out: assert property (p_key_out) else $error("key output lags wrong"); // RULE_03

    property p_internal_free;
        acc_valid && acc_internal |=> acc_grant && !acc_deny;
    endproperty
    a_internal_free: assert property (p_internal_free) else $error("internal access refused"); // RULE_12

    property p_locked;
        acc_valid && !acc_internal && sec_q[1] |=> acc_deny && !acc_grant;
    endproperty
    a_locked: assert property (p_locked) else $error("locked level let access through"); // RULE_11

    property p_enc_frame_only;
        acc_valid && !acc_internal && !sec_q[1] && acc_write && acc_encrypted
            && (acc_reg != FRAME_ADDR_IDX) && (acc_reg != FRAME_DATA_IDX) |=> acc_deny;
    endproperty
    a_enc_frame_only: assert property (p_enc_frame_only) else $error("encrypted write escaped"); // RULE_14

    property p_sec_hold;
        !encrypted_stream_end && !startup_finished |=> $stable(sec_q);
    endproperty
    a_sec_hold: assert property (p_sec_hold) else $error("security level moved early"); // RULE_13

    property p_float;
        !cfg_float_n_s |=> user_io_hiz;
    endproperty
    a_float: assert property (p_float) else $error("configuration float not honoured"); // RULE_19

    property p_pullup;
        !ctl_q[USER_FLOAT_N_BIT] && !cfg_float_n_s |=> pullup_off && user_io_hiz;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups left on"); // RULE_17

    property p_fallback;
        config_failed |=> (fallback_start != $past(ctl_q[FALLBACK_DIS_BIT]))
            && (config_halt || !$past(ctl_q[FALLBACK_DIS_BIT]));
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback choice wrong"); // RULE_07

    property p_persist;
        config_done && !ctl_q[PERSIST_BIT] |=> !cfg_port_active;
    endproperty
    a_persist: assert property (p_persist) else $error("port kept without persist"); // RULE_15

    property p_user_float;
        !ctl_q[USER_FLOAT_N_BIT] |=> user_io_hiz;
    endproperty
    a_user_float: assert property (p_user_float) else $error("user float ignored"); // RULE_16

    property p_heat_off;
        !ctl_q[OVERHEAT_BIT] |=> !overheat_power_down;
    endproperty
    a_heat_off: assert property (p_heat_off) else $error("unwanted power-down"); // RULE_06
endmodule : config_control_word_zero

//--- core/sync2.sv
`timescale 1ns/1ns
// two-flop synchroniser for asynchronous pin levels
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync2

//--- testbench/cfg_packet_model.sv
`timescale 1ns/1ns
// packet processor side of the access checker
module cfg_packet_model (
    // clock
    input wire logic pclk,
    // request to the checker
    output logic acc_valid,
    output logic acc_internal,
    output logic acc_write,
    output logic acc_encrypted,
    output logic [4:0] acc_reg,
    // answer from the checker
    input wire logic acc_grant,
    input wire logic acc_deny
);
    // idle, nothing requested
    initial begin
        acc_valid = 1'b0;
        {acc_internal, acc_write, acc_encrypted, acc_reg} = 8'h00;
    end

    // one check, answer taken one edge after the request
    task automatic check(input logic i, input logic w, input logic e, input logic [4:0] r,
            output logic g, output logic d);
        @(posedge pclk);
        acc_valid <= 1'b1;
        {acc_internal, acc_write, acc_encrypted, acc_reg} <= {i, w, e, r};
        @(posedge pclk);
        acc_valid <= 1'b0;
        // inverted so a checker ignoring valid cannot reuse them
        {acc_internal, acc_write, acc_encrypted, acc_reg} <= ~{i, w, e, r};
        #1;
        g = acc_grant;
        d = acc_deny;
    endtask : check
endmodule : cfg_packet_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench
    import cfg_ctl_pkg::*;
;
    // clock, reset and bus
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, err, g, d;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    // status, pins and outputs
    logic float_n, alarm, sfin, send, cdone, cfail;
    logic av, ai, aw, ae, ag, ad, key, psel_o, pdown, fb, halt, mmask_n, dec, port_on, hiz, pu_off;
    logic [4:0] ar;
    logic [FAR_W-1:0] ecc_a, crc_a, far_o;
    logic [1:0] lvl, l;
    int bad_count, comparisons;

    config_control_word_zero u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_io_float_n(float_n), .overheat_alarm(alarm),
        .startup_finished(sfin), .encrypted_stream_end(send), .config_done(cdone),
        .config_failed(cfail), .ecc_error_frame_addr(ecc_a), .readback_crc_addr(crc_a),
        .acc_valid(av), .acc_internal(ai), .acc_write(aw), .acc_encrypted(ae), .acc_reg(ar),
        .acc_grant(ag), .acc_deny(ad), .key_source_select(key), .internal_port_select(psel_o),
        .overheat_power_down(pdown), .fallback_start(fb), .config_halt(halt),
        .readback_mem_mask_n(mmask_n), .frame_addr_readback(far_o), .decrypt_enable(dec),
        .security_level(lvl), .cfg_port_active(port_on), .user_io_hiz(hiz), .pullup_off(pu_off)
    );

    cfg_packet_model u_pp (
        .pclk(pclk), .acc_valid(av), .acc_internal(ai), .acc_write(aw), .acc_encrypted(ae),
        .acc_reg(ar), .acc_grant(ag), .acc_deny(ad)
    );

    // 100 MHz
    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no fixed wait assumed; a missing answer is left to the watchdog
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic e);
        apb(1'b1, a, wd);
        chk(err, e, "write error");
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, "read data");
        chk(err, e, "read error");
    endtask : rc

    // long enough for a register change or the pin synchroniser to show
    task automatic st;
        repeat (4) @(posedge pclk);
        #1;
    endtask : st

    task automatic pulse(input logic enc);
        @(posedge pclk);
        send <= enc;
        cfail <= !enc;
        @(posedge pclk);
        {send, cfail} <= 2'h0;
        #1;
    endtask : pulse

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, send, cdone, cfail, sfin} = 7'h00;
        {float_n, alarm} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        ecc_a = 24'hA5C3E1;
        crc_a = 24'h5A3C1E;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        st;
        rc(CTL_ADDR, 32'h0000_0481, 1'b0);
        rc(MASK_ADDR, 32'hFFFF_FFFF, 1'b0);
        chk({key, psel_o, pdown, mmask_n, dec, hiz, pu_off, port_on}, 8'h01, "reset");
        chk(far_o, crc_a, "frame addr");
        chk(lvl, 2'h0, "level");
        $display("test reset done");
        wr(CTL_ADDR, 32'h4000_1100, 1'b0);
        st;
        rc(CTL_ADDR, 32'h4000_1100, 1'b0);
        chk({psel_o, pdown, mmask_n, hiz, pu_off}, 5'h1E, "fields");
        chk(far_o, ecc_a, "frame addr");
        @(posedge pclk);
        float_n <= 1'b0;
        st;
        chk({hiz, pu_off}, 2'h3, "pull-ups");
        wr(MASK_ADDR, 32'h0000_0001, 1'b0);
        wr(CTL_ADDR, 32'h0000_0001, 1'b0);
        st;
        rc(CTL_ADDR, 32'h4000_1101, 1'b0);
        chk({hiz, pu_off}, 2'h2, "cfg float");
        @(posedge pclk);
        {float_n, alarm} <= 2'h2;
        st;
        chk({hiz, pdown}, 2'h0, "io active");
        wr(MASK_ADDR, 32'hFFFF_FFFF, 1'b0);
        $display("test fields done");
        @(posedge pclk);
        sfin <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            l = 2'(n);
            wr(CTL_ADDR, {26'h0, l, 4'h0} | 32'h0000_0481, 1'b0);
            st;
            chk(lvl, l, "level");
            for (int k = 0; k < 5; k++) begin
                u_pp.check(k == 4, k inside {[1:3]}, k inside {[2:3]}, (k == 3) ? 5'h01 : 5'h03, g, d);
                chk({g, d}, (k == 0 && l != 0) || (k inside {1, 3} && l[1]) || k == 2 ? 2'h1 : 2'h2,
                    "access");
            end
        end
        @(posedge pclk);
        sfin <= 1'b0;
        wr(CTL_ADDR, 32'h0000_0481, 1'b0);
        st;
        chk(lvl, 2'h3, "level held");
        $display("test security done");
        wr(CTL_ADDR, 32'h0000_0081, 1'b0);
        st;
        pulse(1'b0);
        chk({fb, halt}, 2'h2, "fallback");
        wr(CTL_ADDR, 32'h0000_0481, 1'b0);
        st;
        pulse(1'b0);
        chk({fb, halt}, 2'h1, "halt");
        @(posedge pclk);
        cdone <= 1'b1;
        st;
        chk(port_on, 1'b0, "port released");
        wr(CTL_ADDR, 32'h0000_0489, 1'b0);
        st;
        chk(port_on, 1'b1, "port kept");
        $display("test fallback done");
        wr(CTL_ADDR, 32'h8000_0489, 1'b0);
        st;
        chk(key, 1'b1, "key");
        wr(CTL_ADDR, 32'h0000_04C9, 1'b0);
        st;
        chk({key, dec}, 2'h1, "decrypt");
        wr(CTL_ADDR, 32'h8000_04D9, 1'b0);
        st;
        rc(CTL_ADDR, 32'h8000_04D9, 1'b0);
        chk({key, lvl}, 3'h3, "key frozen");
        pulse(1'b1);
        st;
        chk(lvl, 2'h1, "stream end level");
        $display("test key done");
        rc(8'h40, 32'h0000_0000, 1'b1);
        wr(8'h40, 32'h0000_0000, 1'b1);
        wr(STATE_ADDR, 32'h0000_0000, 1'b1);
        // a byte-partial write is refused and must leave the word alone
        pstrb <= 4'h3;
        wr(CTL_ADDR, 32'h0000_0000, 1'b1);
        pstrb <= 4'hF;
        rc(CTL_ADDR, 32'h8000_04D9, 1'b0);
        // state view: key 0, level 01, halt and port kept, I/Os active
        rc(STATE_ADDR, 32'h0000_0034, 1'b0);
        $display("test refusals done");
        test_done;
    end

    // stop a hung run, the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        test_done;
    end
endmodule : testbench
